// ### csr_port_pkg.sv
// Shared constants and types for the indirect register access block
`default_nettype none

package csr_port_pkg;

    // ==========================================================
    // Widths
    localparam int DATA_W  = 16;
    localparam int INDEX_W = 3;
    localparam int BYTE_W  = 8;

    // ==========================================================
    // Select port fields
    localparam int SEL_LANE_BIT  = 0;
    localparam int SEL_INDEX_LSB = 1;
    localparam int SEL_MODE_BIT  = 7;
    localparam logic [15:0] SEL_WRITE_MASK = 16'h008F;
    localparam logic [15:0] SEL_RESET      = 16'h0000;

    // ==========================================================
    // Register indices
    localparam logic [2:0] MAIN_INDEX = 3'h0;

    // ==========================================================
    // Main control/status fields
    localparam int MCS_POLL_BIT   = 15;
    localparam int MCS_STOP_BIT   = 14;
    localparam int MCS_TXDIS_BIT  = 13;
    localparam int MCS_RXDIS_BIT  = 12;
    localparam int MCS_TRANSMITTER_ACTIVE_FLAG_BIT   = 11;
    localparam int MCS_RECEIVER_ACTIVE_FLAG_BIT   = 10;
    localparam logic MCS_POLL_RESET  = 1'b0;
    localparam logic MCS_STOP_RESET  = 1'b1;
    localparam logic MCS_TXDIS_RESET = 1'b0;
    localparam logic MCS_RXDIS_RESET = 1'b0;

    // ==========================================================
    // Ring access states, Gray coded along off -> on -> drain
    typedef enum logic [1:0] {
        RING_OFF   = 2'b00,
        RING_ON    = 2'b01,
        RING_DRAIN = 2'b11
    } ring_state_t;

endpackage

`default_nettype wire

// ### byte_lane_steer.sv
// Byte lane steering for the data window in 8-bit and 16-bit modes
`default_nettype none

module byte_lane_steer
    import csr_port_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    // Mode
    input  wire logic             byte_mode,
    input  wire logic             upper_lane,
    // Data
    input  wire logic [WIDTH-1:0] host_word,
    input  wire logic [WIDTH-1:0] current_word,
    output logic      [WIDTH-1:0] merged_word,
    output logic      [WIDTH-1:0] lane_mask,
    output logic      [WIDTH-1:0] read_word
);

    localparam int HALF = WIDTH / 2;

    // ==========================================================
    // Merge on write, extract on read
    always_comb begin
        if (!byte_mode) begin
            merged_word = host_word;
            lane_mask   = '1;
            read_word   = current_word;
        end else if (upper_lane) begin
            merged_word = {host_word[HALF-1:0], current_word[HALF-1:0]};
            lane_mask   = {{HALF{1'b1}}, {HALF{1'b0}}};
            read_word   = {{HALF{1'b0}}, current_word[WIDTH-1:HALF]};
        end else begin
            merged_word = {current_word[WIDTH-1:HALF], host_word[HALF-1:0]};
            lane_mask   = {{HALF{1'b0}}, {HALF{1'b1}}};
            read_word   = {{HALF{1'b0}}, current_word[HALF-1:0]};
        end
    end

endmodule

`default_nettype wire

// ### ring_access_gate.sv
// Ring access gate: one descriptor ring's on flag and access enable
`default_nettype none

module ring_access_gate
    import csr_port_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Control
    input  wire logic running,
    input  wire logic ring_disable,
    input  wire logic frame_busy,
    // Status
    output logic      active_flag,
    output logic      ring_enable
);

    ring_state_t state;
    ring_state_t next_state;

    // ==========================================================
    // Next state
    always_comb begin
        next_state = state;
        case (state)
            RING_OFF: begin
                if (running && !ring_disable) begin
                    next_state = RING_ON;
                end
            end
            RING_ON: begin
                if (!running) begin
                    next_state = RING_OFF;
                end else if (ring_disable) begin
                    next_state = frame_busy ? RING_DRAIN : RING_OFF;
                end
            end
            RING_DRAIN: begin
                if (!running || !frame_busy) begin
                    next_state = RING_OFF;
                end else if (!ring_disable) begin
                    next_state = RING_ON;
                end
            end
            default: next_state = RING_OFF;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= RING_OFF;
        end else begin
            state <= next_state;
        end
    end

    assign active_flag = (state != RING_OFF);
    // Ring access is cut in the very cycle the stopped phase begins
    assign ring_enable = (state == RING_ON) && running;

    // ==========================================================
    // Checks
    property p_gate_stop_clears;
        @(posedge clk_sys) disable iff (!rst_n)
        !running |=> !active_flag;
    endproperty
    a_gate_stop_clears: assert property (p_gate_stop_clears)
        else $error("on flag stayed set while stopped");

    property p_gate_drain;
        @(posedge clk_sys) disable iff (!rst_n)
        ring_enable && running && ring_disable && frame_busy
            |=> active_flag && !ring_enable;
    endproperty
    a_gate_drain: assert property (p_gate_drain)
        else $error("ring not drained after disable");

endmodule

`default_nettype wire

// ### indirect_csr_access_and_ring_control.sv
// Indirect register access port and main control/status register
`default_nettype none

// Overview of operation
// - Byte mode set gives 8-bit transfers
// - Byte mode written constant; cleared on reset
// - Select bits 3:1 pick register; reset clears
// - Bit 0 picks high or low byte
// - Data window writes/reads the selected register
// - Index zero maps main control/status register
// - Poll request hastens transmit ring polling
// - Poll bit accepts ones, self-clears, reset clears
// - Stopped phase halts all external activity
// - Stopped flag read-only; reset or stop sets
// - Transmit disable finishes frame, then stops
// - Receive disable finishes frame, then stops
// - Receive disable on link sends RNR/RR
// - Transmitter on flag follows start/disable/stop
// - Receiver on flag follows start/disable/stop
// - Port select low data, high select port
// - Select value held until rewritten or reset

module indirect_csr_access_and_ring_control
    import csr_port_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // Host slave access
    input  wire logic               host_access,
    input  wire logic               host_write,
    input  wire logic               host_port_adr,
    input  wire logic [DATA_W-1:0]  host_wdata,
    output logic      [DATA_W-1:0]  host_rdata,
    output logic                    host_rvalid,
    // Other register bank
    output logic      [INDEX_W-1:0] register_index,
    output logic                    byte_wide_mode,
    output logic                    bank_wr_en,
    output logic      [DATA_W-1:0]  bank_wr_data,
    output logic                    bank_rd_en,
    input  wire logic [DATA_W-1:0]  bank_rd_data,
    // Primitives
    input  wire logic               start_prim,
    input  wire logic               stop_prim,
    // Engine
    input  wire logic               poll_taken,
    input  wire logic               tx_frame_busy,
    input  wire logic               rx_frame_busy,
    input  wire logic               link_established,
    output logic                    transmit_poll_now,
    output logic                    stopped,
    output logic                    tx_ring_enable,
    output logic                    rx_ring_enable,
    output logic                    transmitter_active_flag,
    output logic                    receiver_active_flag,
    output logic                    send_rnr,
    output logic                    send_rr
);

    // ==========================================================
    // Declarations
    logic [DATA_W-1:0] register_select_port;
    logic [DATA_W-1:0] next_select;
    logic              upper_lane_select;

    logic              poll_req;
    logic              next_poll_req;
    logic              next_stopped;
    logic              transmit_ring_disable;
    logic              next_tx_disable;
    logic              receive_ring_disable;
    logic              next_rx_disable;

    logic [DATA_W-1:0] next_rdata;
    logic              next_rvalid;
    logic              next_send_rnr;
    logic              next_send_rr;

    logic              sel_write;
    logic              data_write;
    logic              data_read;
    logic              main_hit;
    logic              main_write;
    logic [DATA_W-1:0] main_control_status;
    logic [DATA_W-1:0] current_word;
    logic [DATA_W-1:0] merged_word;
    logic [DATA_W-1:0] lane_mask;
    logic [DATA_W-1:0] read_word;
    logic              running;

    // ==========================================================
    // Access decode
    assign sel_write  = host_access && host_write && host_port_adr;
    assign data_write = host_access && host_write && !host_port_adr;
    assign data_read  = host_access && !host_write && !host_port_adr;

    assign byte_wide_mode    = register_select_port[SEL_MODE_BIT];
    assign register_index    =
        register_select_port[SEL_INDEX_LSB +: INDEX_W];
    assign upper_lane_select =
        byte_wide_mode && register_select_port[SEL_LANE_BIT];

    assign main_hit   = (register_index == MAIN_INDEX);
    assign main_write = data_write && main_hit;
    assign running    = !stopped;

    // ==========================================================
    // Main control/status view
    always_comb begin
        main_control_status                = '0;
        main_control_status[MCS_POLL_BIT]  = poll_req;
        main_control_status[MCS_STOP_BIT]  = stopped;
        main_control_status[MCS_TXDIS_BIT] = transmit_ring_disable;
        main_control_status[MCS_RXDIS_BIT] = receive_ring_disable;
        main_control_status[MCS_TRANSMITTER_ACTIVE_FLAG_BIT]  = transmitter_active_flag;
        main_control_status[MCS_RECEIVER_ACTIVE_FLAG_BIT]  = receiver_active_flag;
    end

    assign current_word = main_hit ? main_control_status : bank_rd_data;

    byte_lane_steer #(
        .WIDTH        (DATA_W)
    ) u_lane (
        .byte_mode    (byte_wide_mode),
        .upper_lane   (upper_lane_select),
        .host_word    (host_wdata),
        .current_word (current_word),
        .merged_word  (merged_word),
        .lane_mask    (lane_mask),
        .read_word    (read_word)
    );

    // Writes to other registers pass through with the merged lane
    assign bank_wr_en   = data_write && !main_hit;
    assign bank_wr_data = merged_word;
    assign bank_rd_en   = data_read && !main_hit;

    // ==========================================================
    // Select port
    always_comb begin
        next_select = register_select_port;
        if (sel_write) begin
            next_select = host_wdata & SEL_WRITE_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            register_select_port <= SEL_RESET;
        end else begin
            register_select_port <= next_select;
        end
    end

    // ==========================================================
    // Main control/status state
    always_comb begin
        next_poll_req   = poll_req;
        next_stopped    = stopped;
        next_tx_disable = transmit_ring_disable;
        next_rx_disable = receive_ring_disable;
        if (poll_taken || stop_prim) begin
            next_poll_req = 1'b0;
        end
        if (main_write && lane_mask[MCS_POLL_BIT] && merged_word[MCS_POLL_BIT]) begin
            next_poll_req = 1'b1;
        end
        if (main_write && lane_mask[MCS_TXDIS_BIT]) begin
            next_tx_disable = merged_word[MCS_TXDIS_BIT];
        end
        if (main_write && lane_mask[MCS_RXDIS_BIT]) begin
            next_rx_disable = merged_word[MCS_RXDIS_BIT];
        end
        if (start_prim) begin
            next_stopped = 1'b0;
        end
        if (stop_prim) begin
            next_stopped = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            poll_req              <= MCS_POLL_RESET;
            stopped               <= MCS_STOP_RESET;
            transmit_ring_disable <= MCS_TXDIS_RESET;
            receive_ring_disable  <= MCS_RXDIS_RESET;
        end else begin
            poll_req              <= next_poll_req;
            stopped               <= next_stopped;
            transmit_ring_disable <= next_tx_disable;
            receive_ring_disable  <= next_rx_disable;
        end
    end

    // Poll request reaches the engine only outside the stopped phase
    assign transmit_poll_now = poll_req && running;

    // ==========================================================
    // Ring gates
    ring_access_gate u_tx_gate (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .running      (running),
        .ring_disable (transmit_ring_disable),
        .frame_busy   (tx_frame_busy),
        .active_flag  (transmitter_active_flag),
        .ring_enable  (tx_ring_enable)
    );

    ring_access_gate u_rx_gate (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .running      (running),
        .ring_disable (receive_ring_disable),
        .frame_busy   (rx_frame_busy),
        .active_flag  (receiver_active_flag),
        .ring_enable  (rx_ring_enable)
    );

    // ==========================================================
    // Local busy responses and read data
    always_comb begin
        next_send_rnr = running && link_established
                        && next_rx_disable && !receive_ring_disable;
        next_send_rr  = running && link_established
                        && !next_rx_disable && receive_ring_disable;
        next_rvalid   = host_access && !host_write;
        next_rdata    = host_rdata;
        if (host_access && !host_write) begin
            next_rdata = host_port_adr ? register_select_port
                                       : read_word;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            send_rnr    <= 1'b0;
            send_rr     <= 1'b0;
            host_rvalid <= 1'b0;
            host_rdata  <= '0;
        end else begin
            send_rnr    <= next_send_rnr;
            send_rr     <= next_send_rr;
            host_rvalid <= next_rvalid;
            host_rdata  <= next_rdata;
        end
    end

    // ==========================================================
    // Checks
    sequence s_sel_write_word;
        sel_write && !host_wdata[SEL_MODE_BIT];
    endsequence

    sequence s_data_read_word;
        data_read && !byte_wide_mode;
    endsequence

    property p_sel_reserved;
        @(posedge clk_sys) disable iff (!rst_n)
        (register_select_port & ~SEL_WRITE_MASK) == '0;
    endproperty
    a_sel_reserved: assert property (p_sel_reserved)
        else $error("reserved select bits not zero");

    property p_sel_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        !sel_write |=> $stable(register_select_port);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("select port changed without a write");

    property p_word_mode;
        @(posedge clk_sys) disable iff (!rst_n)
        s_sel_write_word |=> !byte_wide_mode ##0 !upper_lane_select;
    endproperty
    a_word_mode: assert property (p_word_mode)
        else $error("byte mode set after word mode write");

    property p_byte_read;
        @(posedge clk_sys) disable iff (!rst_n)
        data_read && byte_wide_mode |=> host_rvalid && host_rdata[15:8] == '0;
    endproperty
    a_byte_read: assert property (p_byte_read)
        else $error("byte read returned high bits");

    property p_main_read;
        @(posedge clk_sys) disable iff (!rst_n)
        s_data_read_word ##0 main_hit
            |=> host_rdata[MCS_TXDIS_BIT] == $past(transmit_ring_disable)
                && host_rdata[MCS_STOP_BIT] == $past(stopped);
    endproperty
    a_main_read: assert property (p_main_read)
        else $error("main register read mismatch");

    property p_poll_sticky;
        @(posedge clk_sys) disable iff (!rst_n)
        poll_req && !poll_taken && !stop_prim |=> poll_req;
    endproperty
    a_poll_sticky: assert property (p_poll_sticky)
        else $error("poll request lost");

    property p_poll_set;
        @(posedge clk_sys) disable iff (!rst_n)
        main_write && !byte_wide_mode && host_wdata[MCS_POLL_BIT] && !stop_prim
            |=> poll_req;
    endproperty
    a_poll_set: assert property (p_poll_set)
        else $error("poll write not taken");

    property p_stop_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        stopped && !start_prim |=> stopped;
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stopped flag cleared without start");

    property p_stop_quiet;
        @(posedge clk_sys) disable iff (!rst_n)
        stopped |-> !tx_ring_enable && !rx_ring_enable && !transmit_poll_now;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("activity in stopped phase");

    property p_rnr;
        @(posedge clk_sys) disable iff (!rst_n)
        running && link_established && $rose(receive_ring_disable)
            |-> send_rnr;
    endproperty
    a_rnr: assert property (p_rnr)
        else $error("no RNR on receive disable");

endmodule

`default_nettype wire

// ### host_cpu_model.sv
// Host processor model driving the select port and data window
`default_nettype none

module host_cpu_model (
    // Clock
    input  wire logic        clk_sys,
    // Host bus
    output logic             host_access,
    output logic             host_write,
    output logic             host_port_adr,
    output logic [15:0]      host_wdata,
    input  wire logic [15:0] host_rdata,
    input  wire logic        host_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        host_access = 1'b0;
        host_write = 1'b0;
        host_port_adr = 1'b0;
        host_wdata = 16'h0000;
    end

    // ==========================================================
    // Legal select word: reserved bits zero, lane zero in word mode
    function automatic logic [15:0] sel_word(input logic m, input logic [2:0] i, input logic l);
        return {8'h00, m, 3'b000, i, l & m};
    endfunction

    // ==========================================================
    // One access: drive after an edge, hold one cycle, take answer
    task automatic access(input logic wr, input logic adr, input logic [15:0] d,
                          output logic [15:0] q);
        @(posedge clk_sys);
        #1;
        host_access = 1'b1;
        host_write = wr;
        host_port_adr = adr;
        host_wdata = d;
        @(posedge clk_sys);
        #1;
        host_access = 1'b0;
        host_wdata = ~d;
        q = (wr || host_rvalid === 1'b1) ? host_rdata : 16'hxxxx;
    endtask
endmodule

`default_nettype wire

// ### indirect_csr_access_and_ring_control_tb.sv
// Self-checking bench for the indirect register access block
`default_nettype none

module indirect_csr_access_and_ring_control_tb
    import csr_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic acc, wr, adr, rv, bwm, bwe, bre;
    logic sta = 1'b0, sto = 1'b0, pt = 1'b0, txb = 1'b0, rxb = 1'b0, lnk = 1'b0;
    logic poll, stp, txe, rxe, txf, rxf, rnr, rr;
    logic [15:0] wd, rd, bwd, q;
    logic [2:0] idx;
    logic [15:0] bank [8] = '{default: 16'h0000};
    logic [15:0] m_bank [8] = '{default: 16'h0000};
    logic [15:0] m_sel;
    logic m_poll, m_stop, m_txd, m_rxd, m_transmitter_active_flag, m_receiver_active_flag;
    logic [31:0] rs = 32'd75522;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_rnr = 0;
    int n_rr = 0;
    int n_brd = 0;

    always #50 clk_sys = ~clk_sys;

    host_cpu_model u_host (.clk_sys(clk_sys), .host_access(acc), .host_write(wr),
        .host_port_adr(adr), .host_wdata(wd), .host_rdata(rd), .host_rvalid(rv));

    indirect_csr_access_and_ring_control i_indirect_csr_access_and_ring_control (
        .clk_sys(clk_sys), .rst_n(rst_n), .host_access(acc), .host_write(wr),
        .host_port_adr(adr), .host_wdata(wd), .host_rdata(rd), .host_rvalid(rv),
        .register_index(idx), .byte_wide_mode(bwm), .bank_wr_en(bwe), .bank_wr_data(bwd),
        .bank_rd_en(bre), .bank_rd_data(bank[idx]), .start_prim(sta), .stop_prim(sto),
        .poll_taken(pt), .tx_frame_busy(txb), .rx_frame_busy(rxb), .link_established(lnk),
        .transmit_poll_now(poll), .stopped(stp), .tx_ring_enable(txe), .rx_ring_enable(rxe),
        .transmitter_active_flag(txf), .receiver_active_flag(rxf), .send_rnr(rnr),
        .send_rr(rr));

    // ==========================================================
    // Outside register bank and response counters
    always @(posedge clk_sys) begin
        if (bwe) begin
            bank[idx] <= bwd;
        end
        n_rnr <= n_rnr + int'(rnr);
        n_rr <= n_rr + int'(rr);
        n_brd <= n_brd + int'(bre);
    end

    // ==========================================================
    // Helpers
    function automatic logic [15:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs[15:0];
    endfunction

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        tick(3);
        rst_n = 1'b1;
        m_sel = 16'h0000;
        {m_poll, m_stop, m_txd, m_rxd, m_transmitter_active_flag, m_receiver_active_flag} = 6'b010000;
    endtask

    task automatic wsel(input logic [15:0] d);
        u_host.access(1'b1, 1'b1, d, q);
        m_sel = d & SEL_WRITE_MASK;
    endtask

    task automatic wdat(input logic [15:0] d);
        logic [2:0] i;
        i = m_sel[3:1];
        u_host.access(1'b1, 1'b0, d, q);
        if (i == 3'h0) begin
            m_poll = m_poll | d[15];
            m_txd = d[13];
            m_rxd = d[12];
        end else if (!m_sel[7]) m_bank[i] = d;
        else if (m_sel[0]) m_bank[i][15:8] = d[7:0];
        else m_bank[i][7:0] = d[7:0];
    endtask

    task automatic rdat(input string nm);
        logic [15:0] w;
        w = (m_sel[3:1] == 3'h0) ? {m_poll, m_stop, m_txd, m_rxd, m_transmitter_active_flag, m_receiver_active_flag, 10'h000}
                                 : m_bank[m_sel[3:1]];
        if (m_sel[7]) w = m_sel[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
        u_host.access(1'b0, 1'b0, 16'h0000, q);
        check(nm, q, w);
    endtask

    task automatic pulse_prim(input logic st);
        tick(1);
        if (st) sta = 1'b1;
        else sto = 1'b1;
        tick(1);
        sta = 1'b0;
        sto = 1'b0;
        tick(2);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        do_reset();
        u_host.access(1'b0, 1'b1, 16'h0000, q);
        check("sel_reset", q, 16'h0000);
        wsel(16'h0072);
        u_host.access(1'b0, 1'b1, 16'h0000, q);
        check("sel_reserved", q, m_sel);
        wsel(u_host.sel_word(1'b0, MAIN_INDEX, 1'b0));
        rdat("main_reset");
        wdat(16'h7C00);
        rdat("main_ro_bits");
        pulse_prim(1'b1);
        m_stop = 1'b0;
        rdat("start_disabled");
        check("txe_disabled", {15'h0, txe}, 16'h0000);
        lnk = 1'b1;
        wdat(16'h0000);
        tick(2);
        {m_transmitter_active_flag, m_receiver_active_flag} = 2'b11;
        rdat("on_after_clear");
        check("enables_on", {14'h0, txe, rxe}, 16'h0003);
        check("rr_sent", 16'(n_rr), 16'h0001);
        wdat(16'h8000);
        check("poll_out", {15'h0, poll}, 16'h0001);
        wdat(16'h0000);
        rdat("poll_held");
        tick(1);
        pt = 1'b1;
        tick(1);
        pt = 1'b0;
        m_poll = 1'b0;
        tick(1);
        check("poll_cleared", {15'h0, poll}, 16'h0000);
        {txb, rxb} = 2'b11;
        wdat(16'h3000);
        tick(2);
        check("drain_flags", {12'h0, txe, rxe, txf, rxf}, 16'h0003);
        check("rnr_sent", 16'(n_rnr), 16'h0001);
        {txb, rxb} = 2'b00;
        tick(3);
        {m_transmitter_active_flag, m_receiver_active_flag} = 2'b00;
        rdat("drained_off");
        wdat(16'h8000);
        tick(2);
        {m_transmitter_active_flag, m_receiver_active_flag} = 2'b11;
        pulse_prim(1'b0);
        {m_stop, m_poll, m_transmitter_active_flag, m_receiver_active_flag} = 4'b1000;
        check("stopped_state", {11'h0, stp, poll, txe, txf, rxf}, 16'h0010);
        rdat("main_stopped");
        for (int i = 1; i < 6; i++) begin
            wsel(u_host.sel_word(1'b0, 3'(i), 1'b0));
            wdat(rnd());
        end
        for (int i = 1; i < 6; i++) begin
            wsel(u_host.sel_word(1'b0, 3'(i), 1'b0));
            rdat("bank_word");
        end
        check("bank_reads", 16'(n_brd), 16'h0005);
        // Byte mode set once after a fresh reset and never changed
        do_reset();
        for (int i = 0; i < 4; i++) begin
            wsel(u_host.sel_word(1'b1, 3'(i > 0), i[0]));
            check("byte_mode", {15'h0, bwm}, 16'h0001);
            if (i > 0) wdat(rnd());
            rdat("byte_lane");
        end
        results();
    end

    initial begin
        #(100 * 3000);
        n_mismatch++;
        results();
    end
endmodule

`default_nettype wire
